// File: src/timer_ctl_regs.svh
// Register offsets, field positions and reset values of the timer mode and
// interrupt control block. Included by the edge detector, the mode control and the bench; definitions only.
`ifndef TIMER_CTL_REGS_SVH
`define TIMER_CTL_REGS_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// --------------------------------------------------------------------------
`define ADDR_WIDTH 4
`define OFF_MODE_CONTROL 4'h0
`define OFF_INT_CONTROL 4'h2
`define OFF_INT_CLEAR 4'h4

// --------------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------------
`define MODE_SEL_LO 0
`define MODE_SEL_HI 1
`define BIT_PIN_ONE_EDGE 2
`define BIT_PIN_TWO_EDGE 3
`define BIT_PIN_ONE_EN 4
`define BIT_PIN_TWO_EN 5
`define BIT_PWM_DATA 6
`define MODE_CONTROL_MASK 8'h7F
`define MODE_CONTROL_RESET 8'h00
`define INT_CONTROL_RESET 8'h00
`define PEND_LO 0
`define PEND_HI 3
`define ENAB_LO 4
`define ENAB_HI 7
`define PRESET_VALUE 16'hFFFF
`define SYNC_STAGES 2

`endif

// File: src/timer_ctl_pkg.sv
// Types shared by the timer mode and interrupt control block.
// Assumes the register header is compiled alongside.
package timer_ctl_pkg;
  // Four operating modes in the order of the two-bit selection field.
  typedef enum logic [1:0] {
    MODE_PWM_COUNTER,
    MODE_DUAL_CAPTURE,
    MODE_DUAL_TIMER,
    MODE_SINGLE_CAPTURE
  } timer_mode_t;
endpackage

// File: src/pin_edge_detect.sv
// Synchroniser and polarity-selectable edge detector for one timer pin.
// Assumes the pin is asynchronous to CLOCK; two flops precede any logic.
// Assumes reset is held for three clocks or more, so the stages flush.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_regs.svh"
module pin_edge_detect (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  input wire logic rising,
  output logic level,
  output logic edge_seen
);
  logic meta;
  logic sync;
  logic last;
  wire is_rise = sync & ~last;
  wire is_fall = ~sync & last;

  // ------------------------------------------------------------------------
  // Synchroniser and history
  // ------------------------------------------------------------------------
  // The first stage feeds only the second stage to keep metastability out.
  // No reset here: the stages flush to the pin level while reset is held, so
  // leaving reset never shows a step from a reset value to an idle-high pin.
  always_ff @(posedge clock)
  begin
    meta <= pin;
    sync <= meta;
    last <= sync;
  end

  // Polarity selects which transition counts as the pin's event; none is
  // reported while reset is held and the stages are still flushing.
  assign edge_seen = ~reset & (rising ? is_rise : is_fall);
  assign level = sync;
endmodule
`default_nettype wire

// File: src/pending_flag.sv
// One interrupt pending flag with its enable gating.
// Assumes set and clear inputs are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pending_flag (
  input wire logic clock,
  input wire logic reset,
  input wire logic hw_set,
  input wire logic sw_set,
  input wire logic sw_clear,
  input wire logic enable,
  output logic pending,
  output logic request
);
  // ------------------------------------------------------------------------
  // Flag storage
  // ------------------------------------------------------------------------
  // A set in the same cycle as a clear wins, so no event is ever lost.
  wire next_pending = hw_set | sw_set | (pending & ~sw_clear);

  always_ff @(posedge clock)
  begin
    if (reset)
      pending <= 1'b0;
    else
      pending <= next_pending;
  end

  // Enable only gates the request; the flag still records the event.
  assign request = pending & enable;
endmodule
`default_nettype wire

// File: src/timer_mode_ctl.sv
// Mode control, pin function and interrupt flag logic of a dual 16-bit timer.
// Assumes counters, prescaler and capture registers live outside and exchange
// mode, edge, preset and event signals with this block on the same CLOCK.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_regs.svh"
module timer_mode_ctl (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [`ADDR_WIDTH-1:0] ADDRESS,
  input wire logic [7:0] WRITE_DATA,
  input wire logic WRITE_STROBE,
  input wire logic READ_STROBE,
  output logic [7:0] READ_DATA,
  input wire logic PIN_ONE_IN,
  output logic PIN_ONE_OUT,
  output logic PIN_ONE_OE,
  input wire logic PIN_TWO_IN,
  input wire logic FIRST_UNDERFLOW,
  input wire logic SECOND_UNDERFLOW,
  input wire logic FIRST_RELOAD,
  input wire logic SECOND_RELOAD,
  input wire logic PULSE_ACCUMULATE,
  output logic [1:0] MODE,
  output logic PIN_ONE_CAPTURE,
  output logic PIN_TWO_CAPTURE,
  output logic PIN_TWO_EVENT,
  output logic COUNT_GATE,
  output logic PRESET_FIRST,
  output logic PRESET_SECOND,
  output logic [15:0] PRESET_VALUE,
  output logic TIMER_IRQ_ONE,
  output logic TIMER_IRQ_TWO
);
  // --------------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------------
  logic [1:0] mode_select;
  logic pin_one_edge_polarity;
  logic pin_two_edge_polarity;
  logic pin_one_enable;
  logic pin_two_enable;
  logic pwm_output_data;
  logic [3:0] source_enable;
  logic [3:0] pending;
  logic [3:0] request;
  logic [3:0] hw_event;
  logic pin_one_level;
  logic pin_two_level;
  logic pin_one_edge;
  logic pin_two_edge;

  // Only the three exact offsets reach a register; other addresses drop writes.
  wire write_mode = WRITE_STROBE & (ADDRESS == `OFF_MODE_CONTROL);
  wire write_int = WRITE_STROBE & (ADDRESS == `OFF_INT_CONTROL);
  wire write_clear = WRITE_STROBE & (ADDRESS == `OFF_INT_CLEAR);

  // Mode decode of the two-bit selection field.
  wire timer_ctl_pkg::timer_mode_t mode = timer_ctl_pkg::timer_mode_t'(mode_select);
  wire mode_pwm = (mode == timer_ctl_pkg::MODE_PWM_COUNTER);
  wire mode_dual_cap = (mode == timer_ctl_pkg::MODE_DUAL_CAPTURE);
  wire mode_dual_tmr = (mode == timer_ctl_pkg::MODE_DUAL_TIMER);
  wire mode_single_cap = (mode == timer_ctl_pkg::MODE_SINGLE_CAPTURE);

  // Pin one is an output in every mode but dual capture, when enabled.
  wire pin_one_is_output = pin_one_enable & ~mode_dual_cap;
  wire pin_one_is_input = pin_one_enable & mode_dual_cap;
  // Pin two enable only matters in the two capture modes.
  wire pin_two_active = pin_two_enable & (mode_dual_cap | mode_single_cap);

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  // Both pins pass the same two-flop synchroniser, so their edges line up.
  pin_edge_detect u_pin_one (
    .clock(CLOCK),
    .reset(RESET),
    .pin(PIN_ONE_IN),
    .rising(pin_one_edge_polarity),
    .level(pin_one_level),
    .edge_seen(pin_one_edge)
  );

  pin_edge_detect u_pin_two (
    .clock(CLOCK),
    .reset(RESET),
    .pin(PIN_TWO_IN),
    .rising(pin_two_edge_polarity),
    .level(pin_two_level),
    .edge_seen(pin_two_edge)
  );

  // Pin one captures in dual capture mode even when disabled; only the preset
  // needs the enable. Pin two captures in both capture modes.
  assign PIN_ONE_CAPTURE = mode_dual_cap & pin_one_edge;
  assign PIN_TWO_CAPTURE = (mode_dual_cap | mode_single_cap) & pin_two_edge;
  // External event clocking for the counters in modes 0 and 2.
  assign PIN_TWO_EVENT = (mode_pwm | mode_dual_tmr) & pin_two_edge;
  // Pulse accumulate gate follows the synchronised level of pin two.
  assign COUNT_GATE = ~PULSE_ACCUMULATE |
                      (pin_two_level == pin_two_edge_polarity);
  // Presets to all ones on an enabled input pin transition in a capture mode.
  assign PRESET_FIRST = (pin_one_is_input & pin_one_edge) |
                        (pin_two_active & mode_dual_cap & pin_two_edge);
  assign PRESET_SECOND = pin_two_active & mode_single_cap & pin_two_edge;
  assign PRESET_VALUE = `PRESET_VALUE;
  // The counters read the raw mode field rather than the decoded strobes.
  assign MODE = mode_select;

  // --------------------------------------------------------------------------
  // Mode control register
  // --------------------------------------------------------------------------
  // Software writes every field; reserved bit 7 is dropped.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      mode_select <= 2'h0;
      pin_one_edge_polarity <= 1'b0;
      pin_two_edge_polarity <= 1'b0;
      pin_one_enable <= 1'b0;
      pin_two_enable <= 1'b0;
    end
    else if (write_mode)
    begin
      mode_select <= WRITE_DATA[`MODE_SEL_HI:`MODE_SEL_LO];
      pin_one_edge_polarity <= WRITE_DATA[`BIT_PIN_ONE_EDGE];
      pin_two_edge_polarity <= WRITE_DATA[`BIT_PIN_TWO_EDGE];
      pin_one_enable <= WRITE_DATA[`BIT_PIN_ONE_EN];
      pin_two_enable <= WRITE_DATA[`BIT_PIN_TWO_EN];
    end
  end

  // --------------------------------------------------------------------------
  // PWM output data bit
  // --------------------------------------------------------------------------
  // Toggle on underflow only while pin one is an output; a software write in
  // the same cycle takes precedence so software can always force the level.
  wire pwm_toggle = pin_one_is_output & FIRST_UNDERFLOW;
  wire next_pwm = write_mode ? WRITE_DATA[`BIT_PWM_DATA] :
                  (pwm_toggle ? ~pwm_output_data : pwm_output_data);

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      pwm_output_data <= 1'b0;
    else
      pwm_output_data <= next_pwm;
  end

  // The data bit reaches the pin only while pin one is an output.
  assign PIN_ONE_OUT = pin_one_is_output & pwm_output_data;
  assign PIN_ONE_OE = pin_one_is_output;

  // --------------------------------------------------------------------------
  // Interrupt enables and pending flags
  // --------------------------------------------------------------------------
  // Enables are plain storage; the pending bits of the same byte live in the flags.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      source_enable <= 4'h0;
    else if (write_int)
      source_enable <= WRITE_DATA[`ENAB_HI:`ENAB_LO];
  end

  // Hardware events per source and mode.
  assign hw_event[0] = FIRST_RELOAD | PIN_ONE_CAPTURE;
  assign hw_event[1] = SECOND_RELOAD | PIN_TWO_CAPTURE;
  assign hw_event[2] = mode_dual_cap & FIRST_UNDERFLOW;
  assign hw_event[3] = SECOND_UNDERFLOW | (mode_dual_tmr & SECOND_RELOAD);

  // Software sets on a one, clears through the clear register only.
  wire [3:0] sw_set = write_int ? WRITE_DATA[`PEND_HI:`PEND_LO] : 4'h0;
  wire [3:0] sw_clear = write_clear ? WRITE_DATA[3:0] : 4'h0;

  // One flag module per source keeps the set-wins ordering in a single place.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_flag
      pending_flag u_flag (
        .clock(CLOCK),
        .reset(RESET),
        .hw_set(hw_event[g]),
        .sw_set(sw_set[g]),
        .sw_clear(sw_clear[g]),
        .enable(source_enable[g]),
        .pending(pending[g]),
        .request(request[g])
      );
    end
  endgenerate

  // Sources A to C share the first system interrupt, D has the second.
  assign TIMER_IRQ_ONE = |request[2:0];
  assign TIMER_IRQ_TWO = request[3];

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Reserved bits and the write-only clear register read as zero.
  wire [7:0] mode_word = {1'b0, pwm_output_data, pin_two_enable, pin_one_enable,
                          pin_two_edge_polarity, pin_one_edge_polarity, mode_select};
  wire [7:0] read_mux = (ADDRESS == `OFF_MODE_CONTROL) ? (mode_word & `MODE_CONTROL_MASK) :
                        (ADDRESS == `OFF_INT_CONTROL) ? {source_enable, pending} :
                        8'h00;

  // Read data fall back to zero, so a value never lingers past its one cycle.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      READ_DATA <= 8'h00;
    else if (READ_STROBE)
      READ_DATA <= read_mux;
    else
      READ_DATA <= 8'h00;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Register reset, pin drive and flag checks.
  a_reset_clears_mode: assert property (@(posedge CLOCK) RESET |=> (MODE == 2'h0) && !PIN_ONE_OE)
    else $error("mode not cleared by reset");
  a_pin_one_oe: assert property (@(posedge CLOCK) disable iff (RESET)
    PIN_ONE_OE == (pin_one_enable && mode_select != 2'h1))
    else $error("pin one drive wrong for mode");
  a_input_no_drive: assert property (@(posedge CLOCK) disable iff (RESET)
    (mode_select == 2'h1) |-> !PIN_ONE_OUT && !PIN_ONE_OE)
    else $error("pin one driven while input");
  a_pwm_toggle: assert property (@(posedge CLOCK) disable iff (RESET)
    (pwm_toggle && !write_mode) |=> pwm_output_data != $past(pwm_output_data))
    else $error("pwm data did not toggle");
  a_sw_precedence: assert property (@(posedge CLOCK) disable iff (RESET)
    write_mode |=> pwm_output_data == $past(WRITE_DATA[`BIT_PWM_DATA]))
    else $error("software write lost");
  a_preset_second: assert property (@(posedge CLOCK) disable iff (RESET)
    (mode_select == 2'h0 || mode_select == 2'h2) |-> !PRESET_SECOND && !PIN_TWO_CAPTURE)
    else $error("pin two active in wrong mode");
  a_set_wins: assert property (@(posedge CLOCK) disable iff (RESET)
    (hw_event[0] && sw_clear[0]) |=> pending[0])
    else $error("set lost to clear");
  a_clear_works: assert property (@(posedge CLOCK) disable iff (RESET)
    (sw_clear[1] && !hw_event[1] && !sw_set[1]) |=> !pending[1])
    else $error("clear failed");
  a_irq_gated: assert property (@(posedge CLOCK) disable iff (RESET)
    TIMER_IRQ_TWO == (pending[3] && source_enable[3]))
    else $error("irq two gating wrong");
  a_read_clear_zero: assert property (@(posedge CLOCK) disable iff (RESET)
    (READ_STROBE && ADDRESS == `OFF_INT_CLEAR) |=> READ_DATA == 8'h00)
    else $error("clear register read nonzero");

  // Pin edges, presets and gating follow the polarity and enable bits.
  a_edge_pol_one: assert property (@(posedge CLOCK) disable iff (RESET)
    pin_one_edge |-> pin_one_level == pin_one_edge_polarity)
    else $error("pin one edge of wrong polarity");
  a_edge_pol_two: assert property (@(posedge CLOCK) disable iff (RESET)
    pin_two_edge |-> pin_two_level == pin_two_edge_polarity)
    else $error("pin two edge of wrong polarity");
  a_gate_closed: assert property (@(posedge CLOCK) disable iff (RESET)
    (PULSE_ACCUMULATE && pin_two_level != pin_two_edge_polarity) |-> !COUNT_GATE)
    else $error("count gate open against pin two level");
  a_preset_one_input: assert property (@(posedge CLOCK) disable iff (RESET)
    (mode_select == 2'h1 && pin_one_enable && pin_one_edge) |-> PRESET_FIRST)
    else $error("pin one edge did not preset first counter");
  a_preset_single: assert property (@(posedge CLOCK) disable iff (RESET)
    (mode_select == 2'h3 && pin_two_enable && pin_two_edge) |-> PRESET_SECOND && !PRESET_FIRST)
    else $error("pin two preset went to wrong counter");
  a_event_modes: assert property (@(posedge CLOCK) disable iff (RESET)
    PIN_TWO_EVENT |-> !mode_select[0])
    else $error("pin two event outside counter modes");

  // The PWM data bit changes only through a toggle or a software write.
  a_pwm_mirror: assert property (@(posedge CLOCK) disable iff (RESET)
    PIN_ONE_OE |-> PIN_ONE_OUT == pwm_output_data)
    else $error("pin one level differs from pwm data");
  a_pwm_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    (!pwm_toggle && !write_mode) |=> $stable(pwm_output_data))
    else $error("pwm data changed without cause");

  // Pending flags stay set until a clear, whatever software writes.
  a_pend_sw_set: assert property (@(posedge CLOCK) disable iff (RESET)
    sw_set[2] |=> pending[2])
    else $error("software set of pending c lost");
  a_pend_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    (pending[0] && !sw_clear[0]) |=> pending[0])
    else $error("pending a dropped without clear");
  a_source_c_mode: assert property (@(posedge CLOCK) disable iff (RESET)
    (FIRST_UNDERFLOW && mode_select != 2'h1 && !pending[2] && !sw_set[2]) |=> !pending[2])
    else $error("source c set outside dual capture");
  a_irq_one_gate: assert property (@(posedge CLOCK) disable iff (RESET)
    (pending[2] && source_enable[2]) |-> TIMER_IRQ_ONE)
    else $error("enabled source c missing from interrupt one");
  a_irq_disabled: assert property (@(posedge CLOCK) disable iff (RESET)
    (source_enable == 4'h0) |-> !TIMER_IRQ_ONE && !TIMER_IRQ_TWO)
    else $error("interrupt raised with enables off");

  // Reset and the read port.
  a_reset_clears_int: assert property (@(posedge CLOCK) RESET |=>
    (source_enable == 4'h0) && (pending == 4'h0))
    else $error("interrupt control not cleared by reset");
  a_read_idle_zero: assert property (@(posedge CLOCK) disable iff (RESET)
    !READ_STROBE |=> READ_DATA == 8'h00)
    else $error("read data not zero without a read");
  a_read_mode_top: assert property (@(posedge CLOCK) disable iff (RESET)
    (READ_STROBE && ADDRESS == `OFF_MODE_CONTROL) |=> !READ_DATA[7])
    else $error("reserved mode bit read nonzero");

  // --------------------------------------------------------------------------
  // Cover points
  // --------------------------------------------------------------------------
  // Main scenarios the bench is meant to reach.
  c_pwm_toggle: cover property (@(posedge CLOCK) disable iff (RESET) pwm_toggle);
  c_preset_first: cover property (@(posedge CLOCK) disable iff (RESET) PRESET_FIRST);
  c_preset_second: cover property (@(posedge CLOCK) disable iff (RESET) PRESET_SECOND);
  c_irq_one: cover property (@(posedge CLOCK) disable iff (RESET) TIMER_IRQ_ONE);
  c_set_and_clear: cover property (@(posedge CLOCK) disable iff (RESET)
    hw_event[0] && sw_clear[0]);
endmodule
`default_nettype wire

// File: dv/pin_partner.sv
// Far-side model of the two timer pins: the external logic wired to them.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic want_one,
  input wire logic want_two,
  input wire logic drive_out,
  input wire logic drive_oe,
  output logic wire_one,
  output logic wire_two
);
  // The external driver yields pin one while the block drives it, so the
  // wire never has two drivers and always shows a defined level.
  assign wire_one = drive_oe ? drive_out : want_one;
  assign wire_two = want_two;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the timer mode and interrupt control block.
// Assumes the design sources and the pin partner model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_regs.svh"
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [`ADDR_WIDTH-1:0] address = 4'h0;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [3:0] ev = 4'h0;
  logic accum = 1'b0;
  logic want_one = 1'b1;
  logic want_two = 1'b1;
  logic [7:0] read_data;
  logic pin_one_out, pin_one_oe, pin_one_wire, pin_two_wire;
  logic [1:0] mode;
  logic cap_one, cap_two, two_event, count_gate, preset_first, preset_second;
  logic irq_one, irq_two;
  logic [15:0] preset_value;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 32'h2FE165A7;
  int pend, en, m, p, i, k;
  logic [7:0] rd, wd;
  logic [3:0] seen, e;
  logic [`ADDR_WIDTH-1:0] a;
  localparam logic [7:0] edge_mode [4] = '{8'h11, 8'h23, 8'h20, 8'h21};
  localparam logic [3:0] edge_exp [4] = '{4'h9, 4'h5, 4'h2, 4'h9};
  localparam logic [7:0] tog_mode [3] = '{8'h10, 8'h11, 8'h00};
  localparam logic [7:0] tog_exp [3] = '{8'h50, 8'h11, 8'h00};

  // Free-running system clock, 50 ns period.
  initial
  begin
    forever #25 clock = ~clock;
  end

  timer_mode_ctl timer_mode_ctl_i (.CLOCK(clock), .RESET(reset), .ADDRESS(address),
    .WRITE_DATA(write_data), .WRITE_STROBE(write_strobe), .READ_STROBE(read_strobe),
    .READ_DATA(read_data), .PIN_ONE_IN(pin_one_wire), .PIN_ONE_OUT(pin_one_out),
    .PIN_ONE_OE(pin_one_oe), .PIN_TWO_IN(pin_two_wire), .FIRST_UNDERFLOW(ev[2]),
    .SECOND_UNDERFLOW(ev[3]), .FIRST_RELOAD(ev[0]), .SECOND_RELOAD(ev[1]),
    .PULSE_ACCUMULATE(accum), .MODE(mode), .PIN_ONE_CAPTURE(cap_one),
    .PIN_TWO_CAPTURE(cap_two), .PIN_TWO_EVENT(two_event), .COUNT_GATE(count_gate),
    .PRESET_FIRST(preset_first), .PRESET_SECOND(preset_second),
    .PRESET_VALUE(preset_value), .TIMER_IRQ_ONE(irq_one), .TIMER_IRQ_TWO(irq_two));

  pin_partner pin_partner_i (.want_one(want_one), .want_two(want_two),
    .drive_out(pin_one_out), .drive_oe(pin_one_oe), .wire_one(pin_one_wire),
    .wire_two(pin_two_wire));

  // --------------------------------------------------------------------------
  // Bus cycles and comparisons
  // --------------------------------------------------------------------------
  task automatic chk8(input string name, input logic [7:0] expv, input logic [7:0] got);
    checks_done++;
    if (got !== expv)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expv, got);
    end
  endtask

  task automatic chk1(input string name, input logic expv, input logic got);
    checks_done++;
    if (got !== expv)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, expv, got);
    end
  endtask

  // One bus cycle with optional counter event pulses alongside; the read
  // data are taken in the cycle after the strobe, the only cycle they stand.
  task automatic cyc(input logic we, input logic re, input logic [`ADDR_WIDTH-1:0] ad,
    input logic [7:0] d, input logic [3:0] evs);
    @(posedge clock);
    write_strobe <= we;
    read_strobe <= re;
    address <= ad;
    write_data <= d;
    ev <= evs;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
    ev <= 4'h0;
    #1 rd = read_data;
  endtask

  task automatic rd_reg(input logic [`ADDR_WIDTH-1:0] ad);
    cyc(1'b0, 1'b1, ad, 8'h00, 4'h0);
  endtask

  // Gathers every strobe seen over six cycles, long enough for the
  // synchroniser and edge compare to deliver one pulse.
  task automatic watch;
    seen = 4'h0;
    repeat (6)
    begin
      @(posedge clock);
      #1 seen = seen | {preset_first, preset_second, two_event, cap_one | cap_two};
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog, well beyond the roughly 700 cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      rd_reg(4'(2 * i));
      chk8("reset read", 8'h00, rd);
    end
    chk8("reset outputs", 8'h00, {mode, pin_one_oe, irq_one, irq_two, 3'h0});
    chk8("preset value high", 8'hFF, preset_value[15:8]);
    chk8("preset value low", 8'hFF, preset_value[7:0]);
    $display("test reset done");
    for (i = 0; i < 24; i++)
    begin
      wd = 8'($random(seed));
      cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, wd, 4'h0);
      rd_reg(`OFF_MODE_CONTROL);
      chk8("mode readback", wd & 8'h7F, rd);
      chk8("mode field", {6'h00, wd[1:0]}, {6'h00, mode});
      chk1("pin one drive", wd[4] && wd[1:0] != 2'b01, pin_one_oe);
      if (pin_one_oe === 1'b1)
        chk1("pin one level", wd[6], pin_one_out);
    end
    $display("test mode register done");
    for (i = 0; i < 3; i++)
    begin
      cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, tog_mode[i], 4'h0);
      cyc(1'b0, 1'b0, `OFF_MODE_CONTROL, 8'h00, 4'h4);
      rd_reg(`OFF_MODE_CONTROL);
      chk8("pwm toggle", tog_exp[i], rd);
    end
    cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, 8'h10, 4'h0);
    cyc(1'b0, 1'b0, `OFF_MODE_CONTROL, 8'h00, 4'h4);
    cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, 8'h50, 4'h4);
    rd_reg(`OFF_MODE_CONTROL);
    chk8("pwm write over toggle", 8'h50, rd);
    chk1("pwm pin level", 1'b1, pin_one_out);
    $display("test pwm output done");
    accum <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, {4'h0, i[1], 3'h0}, 4'h0);
      want_two <= i[0];
      repeat (4) @(posedge clock);
      #1 chk1("count gate", i[1] == i[0], count_gate);
    end
    accum <= 1'b0;
    @(posedge clock);
    #1 chk1("count gate free", 1'b1, count_gate);
    $display("test pulse accumulate done");
    for (p = 0; p < 2; p++)
      for (k = 0; k < 4; k++)
      begin
        want_one <= ~p[0];
        want_two <= ~p[0];
        cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, edge_mode[k] | {4'h0, p[0], p[0], 2'b00}, 4'h0);
        repeat (6) @(posedge clock);
        if (k == 0) want_one <= p[0];
        else want_two <= p[0];
        watch();
        chk8("pin edge", {4'h0, edge_exp[k]}, {4'h0, seen});
        if (k == 0) want_one <= ~p[0];
        else want_two <= ~p[0];
        watch();
        chk8("opposite edge", 8'h00, {4'h0, seen});
      end
    $display("test pin edges done");
    for (m = 0; m < 4; m++)
    begin
      cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, 8'(m), 4'h0);
      cyc(1'b1, 1'b0, `OFF_INT_CLEAR, 8'h0F, 4'h0);
      cyc(1'b0, 1'b0, `OFF_INT_CLEAR, 8'h00, 4'h6);
      rd_reg(`OFF_INT_CONTROL);
      chk8("source c and d by mode", {4'h0, m == 2, m == 1, 2'b00}, rd & 8'h0C);
    end
    $display("test source c done");
    cyc(1'b1, 1'b0, `OFF_MODE_CONTROL, 8'h01, 4'h0);
    cyc(1'b1, 1'b0, `OFF_INT_CLEAR, 8'h0F, 4'h0);
    pend = 0;
    en = 0;
    for (i = 0; i < 80; i++)
    begin
      wd = 8'($random(seed));
      e = 4'($random(seed));
      a = ($random(seed) & 1) ? `OFF_INT_CONTROL : `OFF_INT_CLEAR;
      cyc(1'b1, 1'b0, a, wd, e);
      if (a == `OFF_INT_CONTROL)
      begin
        pend = pend | wd[3:0];
        en = wd[7:4];
      end
      else pend = pend & ~wd[3:0];
      pend = pend | e;
      rd_reg(`OFF_INT_CONTROL);
      chk8("interrupt control", {en[3:0], pend[3:0]}, rd);
      chk1("timer interrupt one", |(pend[2:0] & en[2:0]), irq_one);
      chk1("timer interrupt two", pend[3] & en[3], irq_two);
    end
    rd_reg(`OFF_INT_CLEAR);
    chk8("clear register read", 8'h00, rd);
    $display("test interrupt flags done");
    report_and_stop();
  end
endmodule
`default_nettype wire
